// ---- io_status_defs.svh ----
// Bit positions, page count and reset values for the I/O status word packer.
// Assumes inclusion by bare name from the design files that build the words.
`ifndef IO_STATUS_DEFS_SVH
`define IO_STATUS_DEFS_SVH

// ----------------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------------
`define IOS_WORD_W 16
`define IOS_GEN_N 5
`define IOS_TR_N 3
`define IOS_BIT_FWD 0
`define IOS_BIT_REV 1
`define IOS_BIT_GEN0 2
`define IOS_BIT_TR0 0
`define IOS_BIT_RLY1 4
`define IOS_BIT_ALARM 8
`define IOS_BIT_LFWD 13
`define IOS_BIT_LREV 14
`define IOS_BIT_LRST 15
`define IOS_WORD_RST 16'h0000

// ----------------------------------------------------------------------------
// Paging
// ----------------------------------------------------------------------------
`define IOS_PAGES 6
`define IOS_PAGE_W 3
`define IOS_PAGE_RST 3'h0
`define IOS_PAGE_LAST 3'h5
`define IOS_PAGE_ONE 3'h1

`endif

// ---- io_status_pkg.sv ----
// Types shared by the I/O status word packer.
// Assumes the defines header is compiled alongside it.
`default_nettype none
package io_status_pkg;
    // Presentation style for link-received inputs.
    typedef enum logic {
        SHOW_SEGMENTS,
        SHOW_HEX
    } link_view_t;
endpackage
`default_nettype wire

// ---- io_sync2.sv ----
// Two-flop synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous to clk_sys_i.
`timescale 1ns/10ps
`default_nettype none
module io_sync2 #(
    parameter int W = 8
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Data.
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // io_sync2
`default_nettype wire

// ---- io_page_sel.sv ----
// Page selector for the six-page check view.
// Assumes up and down requests are single-cycle pulses on clk_sys_i.
`include "io_status_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module io_page_sel (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Requests.
    input wire logic up_i,
    input wire logic down_i,
    // Page.
    output logic [`IOS_PAGE_W-1:0] page_o
);
    // Steps one page per request and wraps at either end; both together hold.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            page_o <= `IOS_PAGE_RST;
        else if (up_i && !down_i)
            page_o <= (page_o == `IOS_PAGE_LAST) ? `IOS_PAGE_RST : page_o + `IOS_PAGE_ONE;
        else if (down_i && !up_i)
            page_o <= (page_o == `IOS_PAGE_RST) ? `IOS_PAGE_LAST : page_o - `IOS_PAGE_ONE;
    end

    a_page_wrap_up: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (up_i && !down_i && page_o == `IOS_PAGE_LAST) |=> page_o == `IOS_PAGE_RST)
        else $error("page did not wrap upward");
    a_page_range: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        page_o <= `IOS_PAGE_LAST)
        else $error("page out of range");
endmodule // io_page_sel
`default_nettype wire

// ---- io_status_word_packer.sv ----
// Top of the I/O status word packer: terminal, output and link status words.
// Assumes terminal and relay pins are asynchronous, link bits and keypad
// requests come from logic on clk_sys_i, and registers sit behind AXI4-Lite.
`include "io_status_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module io_status_word_packer (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Terminal block pins, already resolved to active-high.
    input wire logic forward_run_input_i,
    input wire logic reverse_run_input_i,
    input wire logic [`IOS_GEN_N-1:0] general_inputs_i,
    // Output feedback pins.
    input wire logic [`IOS_TR_N-1:0] transistor_outputs_i,
    input wire logic first_relay_contact_i,
    input wire logic alarm_relay_contact_i,
    // Link command bits, same clock.
    input wire logic link_forward_run_i,
    input wire logic link_reverse_run_i,
    input wire logic [`IOS_GEN_N-1:0] link_general_i,
    input wire logic link_forward_command_i,
    input wire logic link_reverse_command_i,
    input wire logic link_fault_reset_i,
    // Keypad page requests, same clock.
    input wire logic page_up_i,
    input wire logic page_down_i,
    // Display words.
    output logic [`IOS_WORD_W-1:0] terminal_input_word_o,
    output logic [`IOS_WORD_W-1:0] output_word_o,
    output logic [`IOS_WORD_W-1:0] link_input_word_o,
    output logic [`IOS_WORD_W-1:0] link_segments_o,
    output logic link_hex_view_o,
    output logic [`IOS_PAGE_W-1:0] page_o,
    // AXI4-Lite write address.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------------
    localparam logic [7:0] ADDR_TERM = 8'h00;
    localparam logic [7:0] ADDR_OUT = 8'h04;
    localparam logic [7:0] ADDR_LINK = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_PAGE = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SYNC_W = 2 + `IOS_GEN_N + `IOS_TR_N + 2;

    // ------------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------------
    logic [SYNC_W-1:0] pins_s;
    logic fwd_s;
    logic rev_s;
    logic [`IOS_GEN_N-1:0] gen_s;
    logic [`IOS_TR_N-1:0] tr_s;
    logic rly_s;
    logic alarm_s;
    logic [`IOS_PAGE_W-1:0] page_w;
    logic valid_q;

    io_sync2 #(
        .W(SYNC_W)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .async_i({alarm_relay_contact_i, first_relay_contact_i, transistor_outputs_i,
                  general_inputs_i, reverse_run_input_i, forward_run_input_i}),
        .sync_o(pins_s)
    );

    // Splits the synchronised vector back into its signals.
    assign {alarm_s, rly_s, tr_s, gen_s, rev_s, fwd_s} = pins_s;

    io_page_sel u_page (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .up_i(page_up_i),
        .down_i(page_down_i),
        .page_o(page_w)
    );

    // ------------------------------------------------------------------------
    // Word packing
    // ------------------------------------------------------------------------
    // Places run and general inputs in the shared terminal layout.
    function automatic logic [`IOS_WORD_W-1:0] pack_inputs(
        input logic forward_run_input,
        input logic reverse_run_input,
        input logic [`IOS_GEN_N-1:0] gen
    );
        logic [`IOS_WORD_W-1:0] w;
        w = `IOS_WORD_RST;
        w[`IOS_BIT_FWD] = forward_run_input;
        w[`IOS_BIT_REV] = reverse_run_input;
        w[`IOS_BIT_GEN0 +: `IOS_GEN_N] = gen;
        return w;
    endfunction

    logic [`IOS_WORD_W-1:0] term_d;
    logic [`IOS_WORD_W-1:0] out_d;
    logic [`IOS_WORD_W-1:0] link_d;

    // Builds the three words from current samples, active signal as 1.
    always_comb
    begin
        term_d = pack_inputs(fwd_s, rev_s, gen_s);
        out_d = `IOS_WORD_RST;
        out_d[`IOS_BIT_TR0 +: `IOS_TR_N] = tr_s;
        out_d[`IOS_BIT_RLY1] = rly_s;
        out_d[`IOS_BIT_ALARM] = alarm_s;
        link_d = pack_inputs(link_forward_run_i, link_reverse_run_i, link_general_i);
        link_d[`IOS_BIT_LFWD] = link_forward_command_i;
        link_d[`IOS_BIT_LREV] = link_reverse_command_i;
        link_d[`IOS_BIT_LRST] = link_fault_reset_i;
    end

    // Marks samples valid once the synchroniser has filled.
    logic fill_q;
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            fill_q <= 1'b0;
            valid_q <= 1'b0;
        end
        else
        begin
            fill_q <= 1'b1;
            valid_q <= fill_q;
        end
    end

    // Refreshes the words every cycle; zero until samples are valid.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            terminal_input_word_o <= `IOS_WORD_RST;
            output_word_o <= `IOS_WORD_RST;
            link_input_word_o <= `IOS_WORD_RST;
        end
        else if (valid_q)
        begin
            terminal_input_word_o <= term_d;
            output_word_o <= out_d;
            link_input_word_o <= link_d;
        end
    end

    // ------------------------------------------------------------------------
    // Link presentation and page
    // ------------------------------------------------------------------------
    io_status_pkg::link_view_t view_q;

    // Segment lamps for link inputs light while the bit is 1; blank in hex view.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            link_segments_o <= `IOS_WORD_RST;
            link_hex_view_o <= 1'b0;
            page_o <= `IOS_PAGE_RST;
        end
        else
        begin
            link_segments_o <= (view_q == io_status_pkg::SHOW_SEGMENTS && valid_q)
                               ? link_d : `IOS_WORD_RST;
            link_hex_view_o <= (view_q == io_status_pkg::SHOW_HEX);
            page_o <= page_w;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------------
    logic [7:0] awaddr_q;
    logic aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held_q;

    // Latches write address and data in either order.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            else if (aw_held_q && w_held_q)
                aw_held_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            else if (aw_held_q && w_held_q)
                w_held_q <= 1'b0;
        end
    end

    // Ready is high while a channel has nothing held and no response waits.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !(s_axi_awvalid && s_axi_awready) && !aw_held_q && !s_axi_bvalid;
            s_axi_wready <= !(s_axi_wvalid && s_axi_wready) && !w_held_q && !s_axi_bvalid;
        end
    end

    // Commits the write and raises the response.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            view_q <= io_status_pkg::SHOW_SEGMENTS;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (aw_held_q && w_held_q)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
            if (awaddr_q == ADDR_CTRL && wstrb_q[0])
                view_q <= wdata_q[0] ? io_status_pkg::SHOW_HEX
                                     : io_status_pkg::SHOW_SEGMENTS;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Answers a read one cycle after the address is taken.
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                unique case (s_axi_araddr)
                    ADDR_TERM: s_axi_rdata <= {16'h0000, terminal_input_word_o};
                    ADDR_OUT: s_axi_rdata <= {16'h0000, output_word_o};
                    ADDR_LINK: s_axi_rdata <= {16'h0000, link_input_word_o};
                    ADDR_CTRL: s_axi_rdata <= {31'h0000_0000, view_q == io_status_pkg::SHOW_HEX};
                    ADDR_PAGE: s_axi_rdata <= {29'h0000_0000, page_o};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_term_run_bits: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        valid_q |=> terminal_input_word_o[1:0] == $past({rev_s, fwd_s}))
        else $error("run bits misplaced in terminal word");
    a_term_general: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        valid_q |=> terminal_input_word_o[6:2] == $past(gen_s))
        else $error("general inputs misplaced");
    a_unassigned_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        terminal_input_word_o[15:7] == 9'h000 && output_word_o[15:9] == 7'h00
        && output_word_o[7:5] == 3'h0 && output_word_o[3] == 1'b0
        && link_input_word_o[12:7] == 6'h00)
        else $error("unassigned bit set");
    a_out_trans: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        valid_q |=> output_word_o[2:0] == $past(tr_s))
        else $error("transistor bits wrong");
    a_out_relay: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        valid_q |=> output_word_o[4] == $past(rly_s))
        else $error("relay bit wrong");
    a_out_alarm: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        valid_q |=> output_word_o[8] == $past(alarm_s))
        else $error("alarm bit wrong");
    a_link_cmds: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        valid_q |=> link_input_word_o[15:13] == $past({link_fault_reset_i,
        link_reverse_command_i, link_forward_command_i}))
        else $error("link command bits wrong");
    a_link_positive: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (valid_q && link_forward_run_i) |=> link_input_word_o[0])
        else $error("link bit inverted");
    a_reset_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !valid_q |=> terminal_input_word_o == 16'h0000 || $past(valid_q))
        else $error("word not zero before first sample");
endmodule // io_status_word_packer
`default_nettype wire

// ---- io_pin_model.sv ----
// Far-side model: terminal block, output feedback contacts and link master.
// Assumes the bench hands it wanted levels; pins follow one edge later.
`timescale 1ns/10ps
`default_nettype none
module io_pin_model (
    // Clock.
    input wire logic clk_sys_i,
    // Wanted levels: terminals, outputs {alarm, relay, transistors}, link.
    input wire logic [6:0] term_i,
    input wire logic [4:0] outs_i,
    input wire logic [9:0] link_i,
    // Terminal and feedback pins.
    output logic forward_run_input_o = 1'b0,
    output logic reverse_run_input_o = 1'b0,
    output logic [4:0] general_inputs_o = 5'h00,
    output logic [2:0] transistor_outputs_o = 3'h0,
    output logic first_relay_contact_o = 1'b0,
    output logic alarm_relay_contact_o = 1'b0,
    // Link command bits.
    output logic [9:0] link_o = 10'h000
);
    // Pins move just after an edge, so the synchronisers see a clean level.
    always @(posedge clk_sys_i)
    begin
        {general_inputs_o, reverse_run_input_o, forward_run_input_o} <= term_i;
        {alarm_relay_contact_o, first_relay_contact_o, transistor_outputs_o} <= outs_i;
        link_o <= link_i;
    end
endmodule // io_pin_model
`default_nettype wire

// ---- tb_io_status_word_packer.sv ----
// Self-checking bench for the I/O status word packer.
// Assumes the design files and the pin model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_io_status_word_packer;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [6:0] term = 7'h00;
    logic [4:0] outs = 5'h00;
    logic [9:0] link = 10'h000;
    logic page_up = 1'b0;
    logic page_down = 1'b0;
    logic forward_run_input, reverse_run_input, rly, alm, hex_v;
    logic [4:0] gen;
    logic [2:0] tr, page;
    logic [9:0] link_input_word;
    logic [15:0] term_w, out_w, link_w, seg_w;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_mismatch = 0;
    int n_compared = 0;

    // 100 MHz system clock.
    always #5 clk_sys_i = ~clk_sys_i;

    // ------------------------------------------------------------------
    // Far side and design
    // ------------------------------------------------------------------
    io_pin_model u_pins (.clk_sys_i(clk_sys_i), .term_i(term), .outs_i(outs), .link_i(link),
        .forward_run_input_o(forward_run_input), .reverse_run_input_o(reverse_run_input), .general_inputs_o(gen),
        .transistor_outputs_o(tr), .first_relay_contact_o(rly),
        .alarm_relay_contact_o(alm), .link_o(link_input_word));
    io_status_word_packer u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .forward_run_input_i(forward_run_input), .reverse_run_input_i(reverse_run_input), .general_inputs_i(gen),
        .transistor_outputs_i(tr), .first_relay_contact_i(rly), .alarm_relay_contact_i(alm),
        .link_forward_run_i(link_input_word[0]), .link_reverse_run_i(link_input_word[1]), .link_general_i(link_input_word[6:2]),
        .link_forward_command_i(link_input_word[7]), .link_reverse_command_i(link_input_word[8]),
        .link_fault_reset_i(link_input_word[9]), .page_up_i(page_up), .page_down_i(page_down),
        .terminal_input_word_o(term_w), .output_word_o(out_w), .link_input_word_o(link_w),
        .link_segments_o(seg_w), .link_hex_view_o(hex_v), .page_o(page),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Counts one comparison and reports a difference at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A bus answer that never came is a mismatch and ends the run.
    task automatic hang();
        chk(32'h0000_0000, 32'h0000_0001);
        finish_test();
    endtask

    // One write; handshakes are judged at the negedge before the taking edge.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hit, w_hit, b_hit;
        b_hit = 1'b0;
        r = 2'h3;
        @(posedge clk_sys_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 64 && !b_hit; i++)
        begin
            @(negedge clk_sys_i);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            r = bresp;
            @(posedge clk_sys_i);
            if (aw_hit)
                awvalid <= 1'b0;
            if (w_hit)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!b_hit)
            hang();
    endtask

    // One read, checked against the expected data and response.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
        logic ar_hit, r_hit;
        logic [31:0] d;
        logic [1:0] r;
        r_hit = 1'b0;
        @(posedge clk_sys_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 64 && !r_hit; i++)
        begin
            @(negedge clk_sys_i);
            ar_hit = arvalid && arready;
            r_hit = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_sys_i);
            if (ar_hit)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!r_hit)
            hang();
        chk(d, exp_d);
        chk({30'h0, r}, {30'h0, exp_r});
    endtask

    // Sets the far-side levels and waits until the words have settled.
    task automatic apply(input logic [6:0] t, input logic [4:0] o, input logic [9:0] l);
        @(posedge clk_sys_i);
        term <= t;
        outs <= o;
        link <= l;
        repeat (5) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    // One keypad request pulse, page checked two edges after it is taken.
    task automatic page_req(input logic u, input logic d, input logic [2:0] exp);
        @(posedge clk_sys_i);
        page_up <= u;
        page_down <= d;
        @(posedge clk_sys_i);
        page_up <= 1'b0;
        page_down <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk({29'h0, page}, {29'h0, exp});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // All pins active through reset; words stay clear until sampling starts.
    task automatic t_reset();
        @(posedge clk_sys_i);
        term <= 7'h7F;
        outs <= 5'h1F;
        link <= 10'h3FF;
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk({term_w, out_w}, 32'h0000_0000);
        chk({link_w, seg_w}, 32'h0000_0000);
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(term_w, 32'h0000_007F);
        chk(out_w, 32'h0000_0117);
        chk(link_w, 32'h0000_E07F);
        chk(seg_w, 32'h0000_E07F);
        rd_chk(8'h0C, 32'h0000_0000, 2'h0);
    endtask

    // Walking one over the terminal inputs, with the sampling latency.
    task automatic t_terminal();
        logic [15:0] prev;
        for (int i = 0; i < 7; i++)
        begin
            prev = term_w;
            @(posedge clk_sys_i);
            term <= 7'(1 << i);
            // Pin moves at the first edge, then two sync stages and the word register.
            repeat (3) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            chk(term_w, prev);
            @(negedge clk_sys_i);
            chk(term_w, 32'h1 << i);
        end
        apply(7'h05, outs, link);
        rd_chk(8'h00, 32'h0000_0005, 2'h0);
    endtask

    // Walking one over transistor, relay and alarm feedback.
    task automatic t_outputs();
        int pos [5] = '{0, 1, 2, 4, 8};
        for (int i = 0; i < 5; i++)
        begin
            apply(term, 5'(1 << i), link);
            chk(out_w, 32'h1 << pos[i]);
        end
        apply(term, 5'h11, link);
        rd_chk(8'h04, 32'h0000_0101, 2'h0);
    endtask

    // Link bits in both views, switched through the control register.
    task automatic t_link();
        int pos [10] = '{0, 1, 2, 3, 4, 5, 6, 13, 14, 15};
        logic [1:0] r;
        for (int i = 0; i < 10; i++)
        begin
            apply(term, outs, 10'(1 << i));
            chk(link_w, 32'h1 << pos[i]);
            chk(seg_w, 32'h1 << pos[i]);
        end
        axi_write(8'h0C, 32'h0000_0001, r);
        chk({30'h0, r}, 32'h0000_0000);
        apply(term, outs, 10'h3FF);
        chk({15'h0, hex_v, seg_w}, 32'h0001_0000);
        rd_chk(8'h08, 32'h0000_E07F, 2'h0);
        rd_chk(8'h0C, 32'h0000_0001, 2'h0);
        axi_write(8'h0C, 32'h0000_0000, r);
        chk({30'h0, r}, 32'h0000_0000);
        apply(term, outs, 10'h181);
        chk({15'h0, hex_v, seg_w}, 32'h0000_6001);
    endtask

    // Writes to read-only and unmapped places are refused without effect.
    task automatic t_bus_err();
        logic [1:0] r;
        axi_write(8'h00, 32'hFFFF_FFFF, r);
        chk({30'h0, r}, 32'h0000_0002);
        rd_chk(8'h00, 32'h0000_0005, 2'h0);
        axi_write(8'h24, 32'h0000_0001, r);
        chk({30'h0, r}, 32'h0000_0002);
        rd_chk(8'h20, 32'h0000_0000, 2'h2);
    endtask

    // Pages step up through all six and wrap both ways.
    task automatic t_page();
        for (int i = 1; i <= 6; i++)
            page_req(1'b1, 1'b0, 3'(i % 6));
        page_req(1'b0, 1'b1, 3'h5);
        page_req(1'b1, 1'b1, 3'h5);
        page_req(1'b0, 1'b1, 3'h4);
        rd_chk(8'h10, 32'h0000_0004, 2'h0);
    endtask

    // Main sequence.
    initial
    begin
        t_reset();
        t_terminal();
        t_outputs();
        t_link();
        t_bus_err();
        t_page();
        finish_test();
    end
endmodule // tb_io_status_word_packer
`default_nettype wire
